//--- rtl/pcc_host_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - one master, eight slaves, sixty-four levels
// - all acknowledges reach every device
// - tell master slave inputs; slave id matches
// - every device gets unique vectors
// - two end commands unless automatic mode
// - input zero is last slave choice
// - clear slave, read it, zero then master
module pcc_host_ctrl (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic [pcc_pkg::AXI_AW-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [pcc_pkg::AXI_AW-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic master_int_i,
   output logic [pcc_pkg::DEV_COUNT-1:0] dev_cs_n_o,
   output logic dev_a0_o,
   output logic dev_wr_n_o,
   output logic dev_rd_n_o,
   output logic vector_acknowledge_strobe_n_o,
   output logic [pcc_pkg::DATA_W-1:0] dev_data_o,
   output logic dev_data_drive_n_o,
   input wire logic [pcc_pkg::DATA_W-1:0] dev_data_i
);
   import pcc_pkg::*;

   // true for the four word addresses of the map
   function automatic logic reg_known(input logic [AXI_AW-1:0] a);
      reg_known = (a == REG_CTRL) || (a == REG_CFG) || (a == REG_VBASE)
         || (a == REG_STATUS);
   endfunction

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      lane_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            lane_merge[8*i +: 8] = nw[8*i +: 8];
         end
      end
   endfunction

   pcc_pin_if pin ();

   // register bus state
   logic aw_have_q; // write address latched
   logic w_have_q; // write data latched
   logic [AXI_AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [31:0] cfg_q; // slave mask and mode options
   logic [31:0] vbase_q; // master and slave vector bases
   // sequencer state
   pcc_state_t st_q;
   logic [DEV_W-1:0] dev_q; // device being initialised
   logic [1:0] step_q; // word index within the device
   logic [2:0] es_id_q; // slave chosen for end of service
   logic from_slv_q; // master end follows a slave end
   logic init_done_q;
   logic [DATA_W-1:0] vec_q; // last vector taken
   logic [DATA_W-1:0] sar_q; // last slave service register read
   logic [7:0] ack_cnt_q;

   // write channel decode
   wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_o;
   wire wr_ctrl = wr_fire && (awaddr_q == REG_CTRL) && wstrb_q[0];
   wire cmd_init = wr_ctrl && wdata_q[CTRL_INIT_BIT];
   wire cmd_ack = wr_ctrl && wdata_q[CTRL_ACK_BIT];
   wire cmd_es = wr_ctrl && wdata_q[CTRL_ES_BIT];
   wire cmd_slv = wdata_q[CTRL_SLV_BIT];
   wire idle = (st_q == ST_IDLE);
   wire rd_take = s_axi_arvalid_i && s_axi_arready_o;

   // configuration fields
   wire [7:0] slave_mask = cfg_q[7:0];
   wire auto_end = cfg_q[CFG_AUTO_BIT];
   wire sfnm_on = cfg_q[CFG_SFNM_BIT];
   wire buf_on = cfg_q[CFG_BUF_BIT];
   // input zero as a slave beside direct inputs is risky: it is also the
   // address the identity lines idle at for a direct request
   wire s0_warn = slave_mask[0] && (slave_mask != ALL_SLAVES);

   // initialisation word for the current device and step
   wire is_master = (dev_q == DEV_MASTER);
   wire [DEV_W-1:0] dev_m1 = dev_q - 1'b1;
   wire [2:0] slv_idx = dev_m1[2:0];
   wire skip_dev = !is_master && !slave_mask[slv_idx];
   // eight slaves of eight levels each give the full sixty-four vectors
   wire [7:0] slv_base = vbase_q[15:8] + {slv_idx, 3'h0};
   wire [7:0] base_word = (is_master ? vbase_q[7:0] : slv_base) & VEC_MASK;
   wire [7:0] casc_word = is_master ? slave_mask : {5'h0, slv_idx};
   // role comes from the mode word only in buffered mode; otherwise the pin decides
   wire [7:0] buf_word = buf_on ? (MCW_BUF | (is_master ? MCW_MS : 8'h00))
      : 8'h00;
   wire [7:0] mode_word = MCW_UPM | (auto_end ? MCW_AUTO : 8'h00) | buf_word
      | ((is_master && sfnm_on) ? MCW_SFNM : 8'h00);
   // cascade flag kept clear so every device takes the cascade word
   wire [7:0] first_word = FIRST_WORD_BASE | FIRST_WORD_MCW;
   wire [7:0] init_word = (step_q == 2'h0) ? first_word : (step_q == 2'h1) ? base_word
      : (step_q == 2'h2) ? casc_word : mode_word;

   // request to the pin engine, held by the state until done
   wire slv_state = (st_q == ST_ES_SLV) || (st_q == ST_RD_CMD) || (st_q == ST_RD_SAR);
   assign pin.req = !idle && (st_q != ST_NEXT) && !((st_q == ST_INIT) && skip_dev);
   assign pin.op = (st_q == ST_ACK) ? OP_ACK : (st_q == ST_RD_SAR) ? OP_READ : OP_WRITE;
   assign pin.sel = (st_q == ST_INIT) ? dev_q : slv_state ? DEV_W'(es_id_q) + 1'b1
      : DEV_MASTER;
   assign pin.a0 = (st_q == ST_INIT) && (step_q != 2'h0);
   assign pin.wdata = (st_q == ST_INIT) ? init_word : (st_q == ST_RD_CMD) ? RD_SAR_CMD
      : ES_CMD;

   pcc_pin_engine #(
      .NDEV(DEV_COUNT)
   ) u_eng (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .pin(pin.eng),
      .dev_cs_n_o(dev_cs_n_o),
      .dev_a0_o(dev_a0_o),
      .dev_wr_n_o(dev_wr_n_o),
      .dev_rd_n_o(dev_rd_n_o),
      .vector_acknowledge_strobe_n_o(vector_acknowledge_strobe_n_o),
      .dev_data_o(dev_data_o),
      .dev_data_drive_n_o(dev_data_drive_n_o),
      .dev_data_i(dev_data_i)
   );

   // write channel: address and data taken in either order
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= reg_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end
   assign s_axi_awready_o = !aw_have_q;
   assign s_axi_wready_o = !w_have_q;

   // configuration registers; status and control words store nothing
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_q <= CFG_RST;
         vbase_q <= VBASE_RST;
      end else if (wr_fire && (awaddr_q == REG_CFG)) begin
         cfg_q <= lane_merge(cfg_q, wdata_q, wstrb_q);
      end else if (wr_fire && (awaddr_q == REG_VBASE)) begin
         vbase_q <= lane_merge(vbase_q, wdata_q, wstrb_q);
      end
   end

   // read channel: one read at a time, answered the cycle after it is taken
   wire [31:0] status_word = {ack_cnt_q, sar_q, vec_q, 4'h0, init_done_q, s0_warn,
      master_int_i, !idle};
   wire [31:0] rd_word = (s_axi_araddr_i == REG_CFG) ? cfg_q
      : (s_axi_araddr_i == REG_VBASE) ? vbase_q
      : (s_axi_araddr_i == REG_STATUS) ? status_word : 32'h0000_0000;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= '0;
         s_axi_rresp_o <= RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_word;
         s_axi_rresp_o <= reg_known(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end
   assign s_axi_arready_o = !s_axi_rvalid_o;

   // sequencer: commands are taken only while idle, others are dropped
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= ST_IDLE;
         dev_q <= DEV_MASTER;
         step_q <= 2'h0;
         es_id_q <= 3'h0;
         from_slv_q <= 1'b0;
         init_done_q <= 1'b0;
         vec_q <= '0;
         sar_q <= '0;
         ack_cnt_q <= 8'h00;
      end else begin
         case (st_q)
            ST_IDLE: if (cmd_init) begin
               // master first, then each attached slave
               dev_q <= DEV_MASTER;
               step_q <= 2'h0;
               init_done_q <= 1'b0;
               st_q <= ST_INIT;
            end else if (cmd_ack) begin
               st_q <= ST_ACK;
            end else if (cmd_es && !auto_end) begin
               // automatic mode needs no end commands at all
               es_id_q <= wdata_q[CTRL_ID_LSB +: 3];
               from_slv_q <= cmd_slv;
               st_q <= cmd_slv ? ST_ES_SLV : ST_ES_MST;
            end
            ST_INIT: if (skip_dev || (pin.done && (step_q == STEP_LAST))) begin
               step_q <= 2'h0;
               st_q <= ST_NEXT;
            end else if (pin.done) begin
               step_q <= step_q + 1'b1;
            end
            ST_NEXT: if (dev_q == DEV_LAST) begin
               init_done_q <= 1'b1;
               st_q <= ST_IDLE;
            end else begin
               dev_q <= dev_q + 1'b1;
               st_q <= ST_INIT;
            end
            ST_ACK: if (pin.done) begin
               // vector from the second pulse, from master or addressed slave
               vec_q <= pin.rdata;
               ack_cnt_q <= ack_cnt_q + 1'b1;
               st_q <= ST_IDLE;
            end
            ST_ES_SLV: if (pin.done) begin
               st_q <= sfnm_on ? ST_RD_CMD : ST_ES_MST;
            end
            ST_RD_CMD: if (pin.done) begin
               st_q <= ST_RD_SAR;
            end
            ST_RD_SAR: if (pin.done) begin
               // other slave levels still in service keep the master's bit
               sar_q <= pin.rdata;
               st_q <= (pin.rdata == '0) ? ST_ES_MST : ST_IDLE;
            end
            ST_ES_MST: if (pin.done) begin
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   wire init_req = pin.req && (st_q == ST_INIT);
   a_master_slaves: assert property (
      init_req && is_master && (step_q == 2'h2) |-> pin.wdata == slave_mask && pin.a0)
      else $error("master cascade word differs from slave mask");
   a_slave_ident: assert property (
      init_req && !is_master && (step_q == 2'h2) |-> pin.wdata == 8'(dev_q - 1'b1))
      else $error("slave identity differs from master input");
   a_vector_base: assert property (
      init_req && (step_q == 2'h1) |-> pin.wdata[2:0] == 3'h0 && pin.sel == dev_q)
      else $error("vector base has low bits set");
   a_cascade_flag: assert property (
      init_req && (step_q == 2'h0) |-> (pin.wdata & SINGLE_DEVICE_FLAG) == 8'h00 && !pin.a0)
      else $error("first word selects single device");
   a_nest_master: assert property (
      init_req && !is_master && (step_q == STEP_LAST) |-> (pin.wdata & MCW_SFNM) == 8'h00)
      else $error("special nesting sent to a slave");
   a_end_pair: assert property (
      (st_q == ST_ES_SLV) && pin.done && !sfnm_on |=> (st_q == ST_ES_MST) && pin.req)
      else $error("slave end not followed by master end");
   a_auto_quiet: assert property (
      idle && cmd_es && auto_end && !cmd_init && !cmd_ack |=> idle [*2])
      else $error("end command issued in automatic mode");
   a_zero_check: assert property (
      (st_q == ST_ES_MST) && from_slv_q && sfnm_on |-> sar_q == '0)
      else $error("master end sent with slave levels in service");
   a_warn_zero: assert property (
      init_req && is_master && (step_q == 2'h2) && pin.wdata[0] && !(&pin.wdata)
      |-> status_word[2])
      else $error("slave on input zero not flagged");
   a_wr_answer: assert property (
      wr_fire |=> s_axi_bvalid_o)
      else $error("write answer missing");
   c_init_done: cover property ((st_q == ST_NEXT) && (dev_q == DEV_LAST));
   c_ack_vec: cover property ((st_q == ST_ACK) && pin.done);
   c_sar_busy: cover property ((st_q == ST_RD_SAR) && pin.done && (pin.rdata != '0));
   c_nest_end: cover property ((st_q == ST_ES_MST) && from_slv_q && sfnm_on && pin.done);
endmodule

//--- inc/pcc_pkg.sv
// shared constants for the cascade host controller
package pcc_pkg;
   // clock and strobe timing, times in ns
   localparam int unsigned CLK_NS = 100;
   localparam int unsigned SETUP_NS = 100; // select to strobe
   localparam int unsigned STROBE_NS = 300; // least strobe width
   localparam int unsigned HOLD_NS = 100; // strobe release to deselect
   localparam int unsigned RECOV_NS = 200; // gap between acknowledge pulses
   localparam int unsigned CNT_W = 4;
   // least times round up to whole cycles
   localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'((STROBE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'((HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] RECOV_CYC = CNT_W'((RECOV_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   // device bus shape: index 0 is the master, 1..8 the slaves
   localparam int unsigned DATA_W = 8;
   localparam int unsigned DEV_COUNT = 9;
   localparam int unsigned DEV_W = 4;
   localparam logic [DEV_W-1:0] DEV_MASTER = 4'h0;
   localparam logic [DEV_W-1:0] DEV_LAST = 4'h8;
   localparam logic [1:0] STEP_LAST = 2'h3;
   // software register map, byte addresses
   localparam int unsigned AXI_AW = 8;
   localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AXI_AW-1:0] REG_CFG = 8'h04;
   localparam logic [AXI_AW-1:0] REG_VBASE = 8'h08;
   localparam logic [AXI_AW-1:0] REG_STATUS = 8'h0c;
   localparam int unsigned CTRL_INIT_BIT = 0;
   localparam int unsigned CTRL_ACK_BIT = 1;
   localparam int unsigned CTRL_ES_BIT = 2;
   localparam int unsigned CTRL_SLV_BIT = 3;
   localparam int unsigned CTRL_ID_LSB = 4;
   localparam int unsigned CFG_AUTO_BIT = 8;
   localparam int unsigned CFG_SFNM_BIT = 9;
   localparam int unsigned CFG_BUF_BIT = 10;
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] VBASE_RST = 32'h0000_4020;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // device command bytes
   localparam logic [7:0] FIRST_WORD_BASE = 8'h10;
   localparam logic [7:0] FIRST_WORD_MCW = 8'h01; // mode word follows
   localparam logic [7:0] SINGLE_DEVICE_FLAG = 8'h02;
   localparam logic [7:0] VEC_MASK = 8'hf8;
   localparam logic [7:0] MCW_UPM = 8'h01;
   localparam logic [7:0] MCW_AUTO = 8'h02;
   localparam logic [7:0] MCW_MS = 8'h04;
   localparam logic [7:0] MCW_BUF = 8'h08;
   localparam logic [7:0] MCW_SFNM = 8'h10;
   localparam logic [7:0] ES_CMD = 8'h20; // non-specific end of service
   localparam logic [7:0] RD_SAR_CMD = 8'h0b; // select service register read
   localparam logic [7:0] ALL_SLAVES = 8'hff;
   typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_ACK} pcc_op_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_INIT, ST_NEXT, ST_ACK, ST_ES_SLV, ST_RD_CMD, ST_RD_SAR, ST_ES_MST
   } pcc_state_t;
endpackage

//--- inc/pcc_pin_if.sv
`timescale 1ns/10ps
// one device bus request from the sequencer to the pin engine
interface pcc_pin_if;
   import pcc_pkg::*;
   logic req; // held until done
   pcc_op_t op;
   logic [DEV_W-1:0] sel;
   logic a0;
   logic [DATA_W-1:0] wdata;
   logic done; // one cycle, last cycle of the transfer
   logic [DATA_W-1:0] rdata; // valid from done onward
   modport seq (output req, op, sel, a0, wdata, input done, rdata);
   modport eng (input req, op, sel, a0, wdata, output done, rdata);
endinterface

//--- rtl/pcc_pin_engine.sv
`timescale 1ns/10ps
// drives the device pins for one write, read or acknowledge sequence
module pcc_pin_engine #(
   parameter int unsigned NDEV = pcc_pkg::DEV_COUNT
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   pcc_pin_if.eng pin,
   output logic [NDEV-1:0] dev_cs_n_o,
   output logic dev_a0_o,
   output logic dev_wr_n_o,
   output logic dev_rd_n_o,
   output logic vector_acknowledge_strobe_n_o,
   output logic [pcc_pkg::DATA_W-1:0] dev_data_o,
   output logic dev_data_drive_n_o,
   input wire logic [pcc_pkg::DATA_W-1:0] dev_data_i
);
   import pcc_pkg::*;
   typedef enum logic [2:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_GAP} pcc_eng_t;
   pcc_eng_t est_q;
   logic [CNT_W-1:0] cnt_q;
   pcc_op_t op_q;
   logic second_q; // second acknowledge pulse under way
   logic [DATA_W-1:0] rdata_q;
   wire last = (cnt_q == CNT_ONE);
   wire more_ack = (op_q == OP_ACK) && !second_q;
   wire [NDEV-1:0] sel_hot = {{(NDEV-1){1'b0}}, 1'b1} << pin.sel;
   assign pin.done = (est_q == E_HOLD) && last && !more_ack;
   assign pin.rdata = rdata_q;
   // acknowledge goes to every device with no select; the data bus is
   // only sampled, since the master or one slave answers on it
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         est_q <= E_IDLE;
         cnt_q <= CNT_ONE;
         op_q <= OP_WRITE;
         second_q <= 1'b0;
         rdata_q <= '0;
         dev_cs_n_o <= '1;
         dev_a0_o <= 1'b0;
         dev_wr_n_o <= 1'b1;
         dev_rd_n_o <= 1'b1;
         vector_acknowledge_strobe_n_o <= 1'b1;
         dev_data_o <= '0;
         dev_data_drive_n_o <= 1'b1;
      end else begin
         case (est_q)
            E_IDLE: if (pin.req) begin
               op_q <= pin.op;
               second_q <= 1'b0;
               dev_cs_n_o <= (pin.op == OP_ACK) ? '1 : ~sel_hot;
               dev_a0_o <= pin.a0;
               dev_data_o <= pin.wdata;
               // bus left free whenever a device answers, so its transceiver can turn
               dev_data_drive_n_o <= (pin.op != OP_WRITE);
               cnt_q <= SETUP_CYC;
               est_q <= E_SETUP;
            end
            E_SETUP: if (last) begin
               dev_wr_n_o <= (op_q != OP_WRITE);
               dev_rd_n_o <= (op_q != OP_READ);
               vector_acknowledge_strobe_n_o <= (op_q != OP_ACK);
               cnt_q <= STROBE_CYC;
               est_q <= E_STROBE;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
            E_STROBE: if (last) begin
               // latch on the strobe's last edge; the second pulse overwrites
               if (op_q != OP_WRITE) begin
                  rdata_q <= dev_data_i;
               end
               dev_wr_n_o <= 1'b1;
               dev_rd_n_o <= 1'b1;
               vector_acknowledge_strobe_n_o <= 1'b1;
               cnt_q <= HOLD_CYC;
               est_q <= E_HOLD;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
            E_HOLD: if (last && more_ack) begin
               cnt_q <= RECOV_CYC;
               est_q <= E_GAP;
            end else if (last) begin
               dev_cs_n_o <= '1;
               dev_data_drive_n_o <= 1'b1;
               est_q <= E_IDLE;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
            E_GAP: if (last) begin
               second_q <= 1'b1;
               vector_acknowledge_strobe_n_o <= 1'b0;
               cnt_q <= STROBE_CYC;
               est_q <= E_STROBE;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
            default: est_q <= E_IDLE;
         endcase
      end
   end
   // checks on the pin waveform
   a_ack_broadcast: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      !vector_acknowledge_strobe_n_o |-> (&dev_cs_n_o) && dev_data_drive_n_o)
      else $error("acknowledge with a select or driven data bus");
   a_write_width: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(dev_wr_n_o) |-> (!dev_wr_n_o && !dev_data_drive_n_o) [*3] ##1 dev_wr_n_o)
      else $error("write strobe not three cycles wide");
   c_two_pulses: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
      second_q && $fell(vector_acknowledge_strobe_n_o));
endmodule

//--- testbench/pcc_dev_model.sv
`timescale 1ns/10ps
// master and eight slaves as the host pins see them
module pcc_dev_model (
   input wire logic [8:0] cs_n_i,
   input wire logic a0_i,
   input wire logic wr_n_i,
   input wire logic rd_n_i,
   input wire logic ack_n_i,
   input wire logic [7:0] data_i,
   input wire logic [2:0] src_i, // requesting master input
   input wire logic [2:0] lvl_i, // level inside that slave
   output logic [7:0] data_o
);
   logic [7:0] base [9], sar [9], mask_q; // vector bases, service regs, slave inputs
   logic [1:0] step [9]; // init words seen since the first word
   logic ph = 1'b0; // high between the two acknowledge pulses
   wire [3:0] sd = {1'b0, src_i} + 4'h1; // device index of the addressed slave
   int rk; // device that was written last, answers reads
   // a released bus shows the inverse of the host data, never a held value
   assign data_o = !rd_n_i ? sar[rk] : (ack_n_i || ph) ? ~data_i : mask_q[src_i] ?
      base[sd] & 8'hf8 | 8'(lvl_i) : base[0] & 8'hf8 | 8'(src_i);
   // writes land when the write strobe rises
   always @(posedge wr_n_i) begin
      for (int k = 0; k < 9; k++) begin
         if (!cs_n_i[k]) begin
            rk = k;
            step[k] <= (!a0_i && data_i[4]) ? 2'h0 : step[k] + 2'(a0_i);
            if (!a0_i && data_i[4]) sar[k] <= 8'h00;
            if (!a0_i && data_i == 8'h20) sar[k] <= sar[k] & (sar[k] - 8'h01);
            if (a0_i && step[k] == 2'h0) base[k] <= data_i;
            if (a0_i && step[k] == 2'h1 && k == 0) mask_q <= data_i;
         end
      end
   end
   // first pulse only sets up; the second marks service in the master and in the addressed slave if attached
   always @(negedge ack_n_i) begin
      ph <= !ph;
      if (ph) sar[0][src_i] <= 1'b1;
      if (ph && mask_q[src_i]) sar[sd][lvl_i] <= 1'b1;
   end
endmodule

//--- testbench/test_pcc_host_ctrl.sv
`timescale 1ns/10ps
// random acknowledge traffic through the register port
module test_pcc_host_ctrl;
   import pcc_pkg::*;
   logic sys_clk_i = 1'b0, nrst_i = 1'b0, master_int_i = 1'b0, s_axi_awvalid_i = 1'b0;
   logic s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic s_axi_rready_i = 1'b0, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_arready_o, s_axi_rvalid_o, dev_a0_o, dev_wr_n_o, dev_rd_n_o, dev_data_drive_n_o;
   logic vector_acknowledge_strobe_n_o;
   logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, dev_data_i, dev_data_o, m_data;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, st;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
   logic [3:0] s_axi_wstrb_i = 4'hf;
   logic [8:0] dev_cs_n_o;
   logic [7:0] mask;
   logic [15:0] vb;
   logic [2:0] src = 3'h0, lvl = 3'h0;
   int failures = 0, check_count = 0, seed = 37639, cyc = 0;
   pcc_host_ctrl dut (.*);
   pcc_dev_model mdl (.cs_n_i(dev_cs_n_o), .a0_i(dev_a0_o), .wr_n_i(dev_wr_n_o),
      .rd_n_i(dev_rd_n_o), .ack_n_i(vector_acknowledge_strobe_n_o), .data_i(dev_data_o),
      .src_i(src), .lvl_i(lvl), .data_o(m_data));
   assign dev_data_i = dev_data_drive_n_o ? m_data : dev_data_o;
   always #50 sys_clk_i = !sys_clk_i;
   // a hung handshake ends the run
   always @(posedge sys_clk_i) if (cyc++ == 20000) begin
      failures++;
      stop_test;
   end
   task automatic stop_test;
      if (failures == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // one register write or read, each channel held until its ready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= {a, a, d};
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{w}};
      {s_axi_arvalid_i, s_axi_rready_i} <= {2{!w}};
      do begin
         @(posedge sys_clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (!(w ? s_axi_bvalid_o : s_axi_rvalid_o));
      {r, st} = w ? {s_axi_bresp_o, st} : {s_axi_rresp_o, s_axi_rdata_o};
      {s_axi_bready_i, s_axi_rready_i} <= 2'b00;
   endtask
   task automatic settle;
      do bus(1'b0, REG_STATUS, 32'h0); while (st[0] !== 1'b0);
   endtask
   // slave levels fill in the low bits of the slave base, direct inputs those of the master base
   function automatic logic [7:0] vec(input logic [15:0] b, input logic [7:0] m,
      input logic [2:0] s, input logic [2:0] l);
      return m[s] ? (b[15:8] + {s, 3'h0}) & 8'hf8 | 8'(l) : b[7:0] & 8'hf8 | 8'(s);
   endfunction
   initial begin
      repeat (5) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      bus(1'b0, REG_VBASE, 32'h0);
      chk("vbase", VBASE_RST, st);
      bus(1'b0, 8'h10, 32'h0);
      chk("rresp", 32'(RESP_SLVERR), 32'(r));
      bus(1'b1, 8'h14, 32'h0);
      chk("bresp", 32'(RESP_SLVERR), 32'(r));
      // second pass mixes input zero in and turns on special nesting
      for (int p = 0; p < 2; p++) begin
         mask = p ? (8'($random(seed)) | 8'h01) & 8'hbf : 8'($random(seed)) & 8'hfe | 8'h80;
         vb = 16'($random(seed));
         bus(1'b1, REG_CFG, {21'h0, p[0], p[0], 1'b0, mask});
         bus(1'b1, REG_VBASE, {16'h0, vb});
         bus(1'b1, REG_CTRL, 32'h1);
         settle;
         chk("cascade", 32'(mask), 32'(mdl.mask_q));
         chk("init done", 32'h1, 32'(st[3]));
         chk("warn", 32'(mask[0] && (mask != 8'hff)), 32'(st[2]));
         repeat (6) begin
            src <= 3'($random(seed));
            lvl <= 3'($random(seed));
            master_int_i <= 1'($random(seed));
            bus(1'b1, REG_CTRL, 32'h2);
            settle;
            chk("int", 32'(master_int_i), 32'(st[1]));
            chk("vector", 32'(vec(vb, mask, src, lvl)), 32'(st[15:8]));
            chk("master sar set", 32'(8'h01 << src), 32'(mdl.sar[0]));
            bus(1'b1, REG_CTRL, {25'h0, src, mask[src], 3'b100});
            settle;
            if (p && mask[src]) chk("slave read", 32'h0, 32'(st[23:16]));
            chk("master sar", 32'h0, 32'(mdl.sar[0]));
         end
      end
      // automatic end mode: an end command must leave the master's service bit alone
      bus(1'b1, REG_CFG, {23'h0, 1'b1, mask});
      bus(1'b1, REG_CTRL, 32'h2);
      settle;
      bus(1'b1, REG_CTRL, 32'h4);
      settle;
      chk("auto end", 32'(8'h01 << src), 32'(mdl.sar[0]));
      chk("acks", 32'h0000_000d, 32'(st[31:24]));
      stop_test;
   end
endmodule
